/* include/pdm_defs.svh */
`ifndef PDM_DEFS_SVH
`define PDM_DEFS_SVH
// How it works
// - Thirteen-bit program counter drives fetch address
// - Program words: 2K, 4K or 8K from zero
// - 2K variant wraps high addresses into 2K
// - 4K variant wraps high addresses into 4K
// - Reset fetches from zero, interrupt from four
// - Two bank bits select bank zero to three
// - Each bank spans local addresses 00h-7Fh
// - Low addresses special registers, rest static RAM or unmapped holes reading zero
// - Special registers everywhere, some mirrored across banks
// - Byte file: 128, 192 or 368 bytes
// - Byte file reachable directly or via pointer
// - Special registers static, core and peripheral sets

// ==========================================
// Program side
`define PDM_PC_W 13
`define PDM_RESET_VEC 13'h0000
`define PDM_IRQ_VEC 13'h0004
`define PDM_WORDS_SMALL 2048
`define PDM_WORDS_MID 4096
`define PDM_WORDS_LARGE 8192

// ==========================================
// Data side: local addresses and core register slots
`define PDM_LOC_INDF 7'h00
`define PDM_LOC_TIMER 7'h01
`define PDM_LOC_PCL 7'h02
`define PDM_LOC_STATUS 7'h03
`define PDM_LOC_PTR 7'h04
`define PDM_LOC_PCLATH 7'h0A
`define PDM_LOC_INTCON 7'h0B
`define PDM_SFR_TOP 7'h20
`define PDM_STATUS_RST 8'h00
`define PDM_ST_BSL 5
`define PDM_ST_BSH 6
`define PDM_ST_IPH 7

// ==========================================
// Byte file layout
`define PDM_GPR_SMALL 128
`define PDM_GPR_MID 192
`define PDM_GPR_LARGE 368
`define PDM_GPR_LO 7'h20
`define PDM_GPR_B1_SMALL_END 7'h40
`define PDM_GPR_HI_LO 7'h10
`define PDM_GPR_LARGE_END 7'h70
`define PDM_COMMON_LO 7'h70
`define PDM_B0_OFF 9'h020
`define PDM_B1_BASE 9'h060
`define PDM_B2_BASE 9'h0B0
`define PDM_B3_BASE 9'h110
`define PDM_HI_OFF 9'h010
`endif

/* include/pdm_pkg.sv */
package pdm_pkg;
    typedef struct packed {
        logic valid;
        logic write;
        logic [6:0] addr;
        logic [7:0] wdata;
    } pdm_data_req_t;

    typedef struct packed {
        logic valid;
        logic sfr_hit;
        logic gpr_hit;
        logic [8:0] addr;
        logic [7:0] rdata;
    } pdm_data_rsp_t;

    typedef struct packed {
        logic step;
        logic jump;
        logic [12:0] target;
        logic irq;
    } pdm_fetch_ctl_t;

    typedef struct packed {
        logic hit;
        logic [8:0] idx;
    } pdm_gpr_hit_t;
endpackage : pdm_pkg

/* hw/pdm_gpr_file.sv */
`timescale 1ns/1ps
`include "pdm_defs.svh"
module pdm_gpr_file #(
    parameter int DEPTH = `PDM_GPR_LARGE
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic we_i,
    input wire logic [8:0] widx_i,
    input wire logic [7:0] wdata_i,
    input wire logic [8:0] ridx_i,
    output logic [7:0] rdata_o
);
    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
    } pdm_gpr_state_t;

    pdm_gpr_state_t st;
    pdm_gpr_state_t next_st;

    generate
        if (DEPTH < 1 || DEPTH > 512)
        begin : g_bad_depth
            $error("pdm_gpr_file: depth out of range");
        end
    endgenerate

    // ==========================================
    // Storage
    // Read is combinational; the caller registers the answer
    always_comb
    begin
        next_st = st;
        if (we_i && int'(widx_i) < DEPTH)
        begin
            next_st.mem[widx_i] = wdata_i;
        end
        rdata_o = (int'(ridx_i) < DEPTH) ? st.mem[ridx_i] : 8'h00;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    a_write_lands: assert property (
        (we_i && int'(widx_i) < DEPTH) |=> (st.mem[$past(widx_i)] == $past(wdata_i)))
        else $error("byte file write lost");
endmodule : pdm_gpr_file

/* hw/pdm_memory_map.sv */
`timescale 1ns/1ps
`include "pdm_defs.svh"
module pdm_memory_map #(
    parameter int PROG_WORDS = `PDM_WORDS_LARGE,
    parameter int GPR_BYTES = `PDM_GPR_LARGE
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire pdm_pkg::pdm_fetch_ctl_t fetch_ctl_i,
    input wire pdm_pkg::pdm_data_req_t data_req_i,
    output logic [12:0] fetch_addr_o,
    output pdm_pkg::pdm_data_rsp_t data_rsp_o,
    output logic [1:0] bank_select_o,
    output logic [7:0] indirect_pointer_o
);
    typedef struct packed {
        logic [12:0] pc;
        logic [7:0] status;
        logic [7:0] indirect_pointer;
        logic [7:0] pclath;
        logic [127:0][7:0] special_function_register;
        pdm_pkg::pdm_data_rsp_t rsp;
    } pdm_map_state_t;

    localparam logic [12:0] PC_MASK = 13'(PROG_WORDS - 1);

    pdm_map_state_t st;
    pdm_map_state_t next_st;
    logic [8:0] eff_addr;
    pdm_pkg::pdm_gpr_hit_t gpr_sel;
    logic sfr_sel;
    logic gpr_we;
    logic [7:0] gpr_rdata;

    // ==========================================
    // Variant checks
    generate
        if (PROG_WORDS != `PDM_WORDS_SMALL && PROG_WORDS != `PDM_WORDS_MID
            && PROG_WORDS != `PDM_WORDS_LARGE)
        begin : g_bad_words
            $error("pdm_memory_map: unsupported program size");
        end
        if (GPR_BYTES != `PDM_GPR_SMALL && GPR_BYTES != `PDM_GPR_MID
            && GPR_BYTES != `PDM_GPR_LARGE)
        begin : g_bad_bytes
            $error("pdm_memory_map: unsupported byte file size");
        end
    endgenerate

    // ==========================================
    // Decoders
    // Byte file placement per variant; upper 16 bytes of banks 1-3 fold to bank 0, except bank 1 of the 192-byte file
    function automatic pdm_pkg::pdm_gpr_hit_t gpr_map(input logic [8:0] a);
        pdm_pkg::pdm_gpr_hit_t r;
        logic [1:0] b;
        logic [6:0] l;
        logic [8:0] lw;
        b = a[8:7];
        l = a[6:0];
        lw = {2'b00, l};
        r.hit = 1'b0;
        r.idx = 9'h000;
        if (b == 2'b00 && l >= `PDM_GPR_LO)
        begin
            r.hit = 1'b1;
            r.idx = lw - `PDM_B0_OFF;
        end
        else if (GPR_BYTES == `PDM_GPR_SMALL && b == 2'b01 && l >= `PDM_GPR_LO
                 && l < `PDM_GPR_B1_SMALL_END)
        begin
            r.hit = 1'b1;
            r.idx = `PDM_B1_BASE + lw - `PDM_B0_OFF;
        end
        else if (GPR_BYTES == `PDM_GPR_MID && b == 2'b01 && l >= `PDM_GPR_LO)
        begin
            r.hit = 1'b1;
            r.idx = `PDM_B1_BASE + lw - `PDM_B0_OFF;
        end
        else if (GPR_BYTES == `PDM_GPR_LARGE && b == 2'b01 && l >= `PDM_GPR_LO
                 && l < `PDM_GPR_LARGE_END)
        begin
            r.hit = 1'b1;
            r.idx = `PDM_B1_BASE + lw - `PDM_B0_OFF;
        end
        else if (GPR_BYTES == `PDM_GPR_LARGE && b[1] && l >= `PDM_GPR_HI_LO
                 && l < `PDM_GPR_LARGE_END)
        begin
            r.hit = 1'b1;
            r.idx = (b[0] ? `PDM_B3_BASE : `PDM_B2_BASE) + lw - `PDM_HI_OFF;
        end
        else if (l >= `PDM_COMMON_LO)
        begin
            r.hit = 1'b1;
            r.idx = lw - `PDM_B0_OFF;
        end
        return r;
    endfunction : gpr_map

    // Core registers live in one slot, seen from every bank, except timer: one slot for banks 0 and 2, one for banks 1 and 3
    function automatic logic [6:0] sfr_idx(input logic [8:0] a);
        logic [6:0] l;
        l = a[6:0];
        if (l == `PDM_LOC_INDF || l == `PDM_LOC_PCL || l == `PDM_LOC_STATUS
            || l == `PDM_LOC_PTR || l == `PDM_LOC_PCLATH || l == `PDM_LOC_INTCON)
        begin
            return {2'b00, l[4:0]};
        end
        if (l == `PDM_LOC_TIMER)
        begin
            return {1'b0, a[7], l[4:0]};
        end
        return {a[8:7], l[4:0]};
    endfunction : sfr_idx

    // ==========================================
    // Byte file
    pdm_gpr_file #(
        .DEPTH(GPR_BYTES)
    ) u_gpr (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .we_i(gpr_we),
        .widx_i(gpr_sel.idx),
        .wdata_i(data_req_i.wdata),
        .ridx_i(gpr_sel.idx),
        .rdata_o(gpr_rdata)
    );

    // ==========================================
    // Next state
    always_comb
    begin
        next_st = st;
        if (data_req_i.addr == `PDM_LOC_INDF)
        begin
            eff_addr = {st.status[`PDM_ST_IPH], st.indirect_pointer};
        end
        else
        begin
            eff_addr = {st.status[`PDM_ST_BSH], st.status[`PDM_ST_BSL],
                        data_req_i.addr};
        end
        gpr_sel = gpr_map(eff_addr);
        sfr_sel = !gpr_sel.hit && eff_addr[6:0] < `PDM_SFR_TOP;
        gpr_we = data_req_i.valid && data_req_i.write && gpr_sel.hit;

        next_st.rsp.valid = data_req_i.valid;
        next_st.rsp.sfr_hit = data_req_i.valid && sfr_sel;
        next_st.rsp.gpr_hit = data_req_i.valid && gpr_sel.hit;
        next_st.rsp.addr = eff_addr;
        next_st.rsp.rdata = 8'h00;
        // Unmapped holes read as zero
        if (data_req_i.valid && gpr_sel.hit)
        begin
            next_st.rsp.rdata = gpr_rdata;
        end
        else if (data_req_i.valid && sfr_sel)
        begin
            unique case (eff_addr[6:0])
                `PDM_LOC_INDF: next_st.rsp.rdata = 8'h00;
                `PDM_LOC_PCL: next_st.rsp.rdata = st.pc[7:0];
                `PDM_LOC_STATUS: next_st.rsp.rdata = st.status;
                `PDM_LOC_PTR: next_st.rsp.rdata = st.indirect_pointer;
                `PDM_LOC_PCLATH: next_st.rsp.rdata = st.pclath;
                default: next_st.rsp.rdata = st.special_function_register[sfr_idx(eff_addr)];
            endcase
        end

        // Pointer aimed at itself writes nothing
        if (data_req_i.valid && data_req_i.write && sfr_sel)
        begin
            unique case (eff_addr[6:0])
                `PDM_LOC_INDF: next_st.special_function_register[0] = st.special_function_register[0];
                `PDM_LOC_PCL: next_st.special_function_register[0] = st.special_function_register[0];
                `PDM_LOC_STATUS: next_st.status = data_req_i.wdata;
                `PDM_LOC_PTR: next_st.indirect_pointer = data_req_i.wdata;
                `PDM_LOC_PCLATH: next_st.pclath = data_req_i.wdata;
                default: next_st.special_function_register[sfr_idx(eff_addr)] = data_req_i.wdata;
            endcase
        end

        // Interrupt beats jump, jump beats counter write, which beats step
        if (fetch_ctl_i.irq)
        begin
            next_st.pc = `PDM_IRQ_VEC;
        end
        else if (fetch_ctl_i.jump)
        begin
            next_st.pc = fetch_ctl_i.target & PC_MASK;
        end
        else if (data_req_i.valid && data_req_i.write && sfr_sel
                 && eff_addr[6:0] == `PDM_LOC_PCL)
        begin
            next_st.pc = {st.pclath[4:0], data_req_i.wdata} & PC_MASK;
        end
        else if (fetch_ctl_i.step)
        begin
            next_st.pc = (st.pc + 13'h0001) & PC_MASK;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!resetn_i)
        begin
            st <= '0;
            st.status <= `PDM_STATUS_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign fetch_addr_o = st.pc;
    assign data_rsp_o = st.rsp;
    assign bank_select_o = {st.status[`PDM_ST_BSH], st.status[`PDM_ST_BSL]};
    assign indirect_pointer_o = st.indirect_pointer;

    // ==========================================
    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    logic req_rd;
    logic req_wr;
    assign req_rd = data_req_i.valid && !data_req_i.write;
    assign req_wr = data_req_i.valid && data_req_i.write;

    sequence s_store;
        req_wr && gpr_sel.hit;
    endsequence
    sequence s_reread;
        req_rd && !fetch_ctl_i.irq && eff_addr == $past(eff_addr);
    endsequence

    a_reset_vector: assert property (
        @(posedge sys_clk_i) disable iff (1'b0)
        !resetn_i |=> fetch_addr_o == `PDM_RESET_VEC)
        else $error("fetch not at zero after reset");
    a_irq_vector: assert property (
        fetch_ctl_i.irq |=> fetch_addr_o == `PDM_IRQ_VEC)
        else $error("interrupt did not vector to four");
    a_pc_wrap: assert property (
        int'(fetch_addr_o) < PROG_WORDS)
        else $error("fetch address beyond program space");
    a_step_counts: assert property (
        (fetch_ctl_i.step && !fetch_ctl_i.irq && !fetch_ctl_i.jump && !req_wr)
        |=> fetch_addr_o == (($past(fetch_addr_o) + 13'h0001) & PC_MASK))
        else $error("counter step wrong");
    a_bank_decode: assert property (
        (req_wr && sfr_sel && eff_addr[6:0] == `PDM_LOC_STATUS)
        |=> bank_select_o == $past(data_req_i.wdata[`PDM_ST_BSH:`PDM_ST_BSL]))
        else $error("bank bits not taken from status");
    a_direct_addr: assert property (
        (data_req_i.valid && data_req_i.addr != `PDM_LOC_INDF)
        |=> data_rsp_o.addr == {$past(bank_select_o), $past(data_req_i.addr)})
        else $error("direct address not bank over operand");
    a_ptr_addr: assert property (
        (data_req_i.valid && data_req_i.addr == `PDM_LOC_INDF)
        |=> data_rsp_o.addr == {$past(st.status[`PDM_ST_IPH]), $past(indirect_pointer_o)})
        else $error("pointer access used wrong address");
    a_gpr_reread: assert property (
        s_store ##1 s_reread |=> data_rsp_o.rdata == $past(data_req_i.wdata, 2))
        else $error("byte file lost a write");
    a_status_mirror: assert property (
        (req_rd && !gpr_sel.hit && eff_addr[6:0] == `PDM_LOC_STATUS)
        |=> data_rsp_o.sfr_hit && data_rsp_o.rdata == $past(st.status))
        else $error("status not mirrored");
    a_gpr_bound: assert property (
        gpr_sel.hit |-> int'(gpr_sel.idx) < GPR_BYTES)
        else $error("byte index beyond file");
    a_hole_zero: assert property (
        (data_rsp_o.valid && !data_rsp_o.sfr_hit && !data_rsp_o.gpr_hit)
        |-> data_rsp_o.rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule : pdm_memory_map

/* testbench/pdm_cpu_model.sv */
`timescale 1ns/1ps
module pdm_cpu_model (
    output pdm_pkg::pdm_fetch_ctl_t fetch_ctl_o,
    output pdm_pkg::pdm_data_req_t data_req_o
);
    // ==========================================
    // Core side request driver
    initial
    begin
        fetch_ctl_o = '0;
        data_req_o = '0;
    end

    // Payload under an idle qualifier flips so stale values can never look valid
    task automatic issue(input pdm_pkg::pdm_fetch_ctl_t c, input pdm_pkg::pdm_data_req_t q);
        logic [12:0] t;
        logic [6:0] a;
        logic [7:0] w;
        t = fetch_ctl_o.target;
        a = data_req_o.addr;
        w = data_req_o.wdata;
        fetch_ctl_o = c;
        data_req_o = q;
        if (!c.jump)
        begin
            fetch_ctl_o.target = ~t;
        end
        if (!q.valid)
        begin
            data_req_o.addr = ~a;
            data_req_o.wdata = ~w;
        end
    endtask : issue
endmodule : pdm_cpu_model

/* testbench/program_data_memory_map_tb_top.sv */
`timescale 1ns/1ps
`include "pdm_defs.svh"
module program_data_memory_map_tb_top;
    // ==========================================
    // Rows and three size variants run in lockstep
    typedef struct packed {
        logic [2:0] c;
        logic [12:0] t;
        logic [1:0] op;
        logic [6:0] a;
        logic [7:0] wd;
        logic [12:0] fa;
        logic [2:0] en;
        logic special_function_register;
        logic gpr;
        logic [8:0] ea;
        logic [7:0] rd;
        logic [1:0] bk;
    } pdm_row_t;
    localparam int PW [3] = '{`PDM_WORDS_SMALL, `PDM_WORDS_MID, `PDM_WORDS_LARGE};
    localparam int GB [3] = '{`PDM_GPR_SMALL, `PDM_GPR_MID, `PDM_GPR_LARGE};
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    pdm_pkg::pdm_fetch_ctl_t ctl;
    pdm_pkg::pdm_data_req_t req;
    logic [12:0] fa [3];
    pdm_pkg::pdm_data_rsp_t rsp [3];
    logic [1:0] bk [3];
    logic [7:0] ptr [3];
    pdm_row_t rows [$];
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;

    always #2.5 sys_clk = ~sys_clk;

    pdm_cpu_model cpu (.fetch_ctl_o(ctl), .data_req_o(req));
    for (genvar g = 0; g < 3; g++)
    begin : g_var
        pdm_memory_map #(.PROG_WORDS(PW[g]), .GPR_BYTES(GB[g])) dut (
            .sys_clk_i(sys_clk), .resetn_i(resetn), .fetch_ctl_i(ctl), .data_req_i(req),
            .fetch_addr_o(fa[g]), .data_rsp_o(rsp[g]), .bank_select_o(bk[g]),
            .indirect_pointer_o(ptr[g]));
    end

    // ==========================================
    // Compare and report
    task automatic tally(input string name, input bit ok, input logic [12:0] e, s);
        checks_done++;
        if (!ok)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", name, e, s);
        end
    endtask : tally
    task automatic chk_addr(input string name, input logic [12:0] e, s);
        tally(name, s === e, e, s);
    endtask : chk_addr
    task automatic chk_byte(input string name, input logic [7:0] e, s);
        tally(name, s === e, {5'h00, e}, {5'h00, s});
    endtask : chk_byte
    task automatic chk_flag(input string name, input logic e, s);
        tally(name, s === e, {12'h000, e}, {12'h000, s});
    endtask : chk_flag
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    // Hang guard, the whole run needs well under a hundred cycles
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 1000)
        begin
            n_fail++;
            conclude();
        end
    end

    // ==========================================
    // Row handling
    task automatic add(input logic [2:0] c, input logic [12:0] t, input logic [1:0] op,
        input logic [6:0] a, input logic [7:0] wd, input logic [12:0] f, input logic [2:0] en,
        input logic special_function_register, gpr, input logic [8:0] ea, input logic [7:0] rd, input logic [1:0] b);
        rows.push_back('{c, t, op, a, wd, f, en, special_function_register, gpr, ea, rd, b});
    endtask : add
    task automatic check_row(input pdm_row_t r);
        for (int i = 0; i < 3; i++)
        begin
            if (r.en[i])
            begin
                chk_addr("fetch", r.fa & 13'(PW[i] - 1), fa[i]);
                chk_addr("bank", {11'h000, r.bk}, {11'h000, bk[i]});
                chk_flag("valid", r.op[1], rsp[i].valid);
                if (r.op[1])
                begin
                    chk_flag("sfr", r.special_function_register, rsp[i].sfr_hit);
                    chk_flag("gpr", r.gpr, rsp[i].gpr_hit);
                    chk_addr("eaddr", {4'h0, r.ea}, {4'h0, rsp[i].addr});
                    if (!r.op[0]) chk_byte("rdata", r.rd, rsp[i].rdata);
                end
            end
        end
    endtask : check_row
    // Back to back: one row per cycle, checked at the next falling edge
    task automatic run_rows();
        pdm_pkg::pdm_fetch_ctl_t c;
        pdm_pkg::pdm_data_req_t q;
        for (int i = 0; i <= rows.size(); i++)
        begin
            if (i > 0) check_row(rows[i - 1]);
            c = '0;
            q = '0;
            if (i < rows.size())
            begin
                c = '{step: rows[i].c[0], jump: rows[i].c[1],
                      target: rows[i].t, irq: rows[i].c[2]};
                q = '{valid: rows[i].op[1], write: rows[i].op[0],
                      addr: rows[i].a, wdata: rows[i].wd};
            end
            cpu.issue(c, q);
            @(negedge sys_clk);
        end
    endtask : run_rows
    task automatic reset_pulse();
        resetn = 1'b0;
        repeat (3) @(negedge sys_clk);
        resetn = 1'b1;
        @(negedge sys_clk);
        for (int i = 0; i < 3; i++)
        begin
            chk_addr("fetch", 13'h0000, fa[i]);
            chk_addr("bank", 13'h0000, {11'h000, bk[i]});
            chk_byte("pointer", 8'h00, ptr[i]);
            chk_flag("valid", 1'h0, rsp[i].valid);
        end
    endtask : reset_pulse

    // ==========================================
    // Main sequence
    initial
    begin
        reset_pulse();
        add(3'h1,13'h0000,2'h0,7'h00,8'h00,13'h0001,3'h7,1'h0,1'h0,9'h000,8'h00,2'h0);
        add(3'h1,13'h0000,2'h3,7'h20,8'hAA,13'h0002,3'h7,1'h0,1'h1,9'h020,8'h00,2'h0);
        add(3'h0,13'h0000,2'h2,7'h20,8'h00,13'h0002,3'h7,1'h0,1'h1,9'h020,8'hAA,2'h0);
        add(3'h4,13'h0000,2'h3,7'h03,8'h20,13'h0004,3'h7,1'h1,1'h0,9'h003,8'h00,2'h1);
        add(3'h2,13'h1FFF,2'h2,7'h03,8'h00,13'h1FFF,3'h7,1'h1,1'h0,9'h083,8'h20,2'h1);
        add(3'h1,13'h0000,2'h3,7'h20,8'h55,13'h0000,3'h7,1'h0,1'h1,9'h0A0,8'h00,2'h1);
        add(3'h6,13'h0ABC,2'h2,7'h20,8'h00,13'h0004,3'h7,1'h0,1'h1,9'h0A0,8'h55,2'h1);
        add(3'h2,13'h0ABC,2'h3,7'h03,8'h40,13'h0ABC,3'h7,1'h1,1'h0,9'h083,8'h00,2'h2);
        add(3'h0,13'h0000,2'h2,7'h03,8'h00,13'h0ABC,3'h7,1'h1,1'h0,9'h103,8'h40,2'h2);
        add(3'h0,13'h0000,2'h3,7'h03,8'h60,13'h0ABC,3'h7,1'h1,1'h0,9'h103,8'h00,2'h3);
        add(3'h0,13'h0000,2'h2,7'h03,8'h00,13'h0ABC,3'h7,1'h1,1'h0,9'h183,8'h60,2'h3);
        add(3'h0,13'h0000,2'h3,7'h03,8'h20,13'h0ABC,3'h7,1'h1,1'h0,9'h183,8'h00,2'h1);
        add(3'h0,13'h0000,2'h3,7'h3F,8'h11,13'h0ABC,3'h7,1'h0,1'h1,9'h0BF,8'h00,2'h1);
        add(3'h0,13'h0000,2'h2,7'h3F,8'h00,13'h0ABC,3'h7,1'h0,1'h1,9'h0BF,8'h11,2'h1);
        add(3'h0,13'h0000,2'h3,7'h40,8'h22,13'h0ABC,3'h6,1'h0,1'h1,9'h0C0,8'h00,2'h1);
        add(3'h0,13'h0000,2'h2,7'h40,8'h00,13'h0ABC,3'h1,1'h0,1'h0,9'h0C0,8'h00,2'h1);
        add(3'h0,13'h0000,2'h2,7'h40,8'h00,13'h0ABC,3'h6,1'h0,1'h1,9'h0C0,8'h22,2'h1);
        add(3'h0,13'h0000,2'h3,7'h03,8'h60,13'h0ABC,3'h7,1'h1,1'h0,9'h083,8'h00,2'h3);
        add(3'h0,13'h0000,2'h3,7'h6F,8'h33,13'h0ABC,3'h4,1'h0,1'h1,9'h1EF,8'h00,2'h3);
        add(3'h0,13'h0000,2'h2,7'h6F,8'h00,13'h0ABC,3'h4,1'h0,1'h1,9'h1EF,8'h33,2'h3);
        add(3'h0,13'h0000,2'h3,7'h03,8'h00,13'h0ABC,3'h7,1'h1,1'h0,9'h183,8'h00,2'h0);
        add(3'h0,13'h0000,2'h3,7'h04,8'h21,13'h0ABC,3'h7,1'h1,1'h0,9'h004,8'h00,2'h0);
        add(3'h0,13'h0000,2'h3,7'h00,8'h5A,13'h0ABC,3'h7,1'h0,1'h1,9'h021,8'h00,2'h0);
        add(3'h0,13'h0000,2'h2,7'h21,8'h00,13'h0ABC,3'h7,1'h0,1'h1,9'h021,8'h5A,2'h0);
        add(3'h0,13'h0000,2'h3,7'h05,8'h3C,13'h0ABC,3'h7,1'h1,1'h0,9'h005,8'h00,2'h0);
        add(3'h0,13'h0000,2'h2,7'h05,8'h00,13'h0ABC,3'h7,1'h1,1'h0,9'h005,8'h3C,2'h0);
        add(3'h0,13'h0000,2'h2,7'h7F,8'h00,13'h0ABC,3'h7,1'h0,1'h1,9'h07F,8'h00,2'h0);
        add(3'h0,13'h0000,2'h3,7'h0A,8'h01,13'h0ABC,3'h7,1'h1,1'h0,9'h00A,8'h00,2'h0);
        add(3'h0,13'h0000,2'h2,7'h0A,8'h00,13'h0ABC,3'h7,1'h1,1'h0,9'h00A,8'h01,2'h0);
        add(3'h0,13'h0000,2'h2,7'h04,8'h00,13'h0ABC,3'h7,1'h1,1'h0,9'h004,8'h21,2'h0);
        add(3'h0,13'h0000,2'h2,7'h00,8'h00,13'h0ABC,3'h7,1'h0,1'h1,9'h021,8'h5A,2'h0);
        // Shared slots: timer seen by banks 0 and 2, control byte by all
        add(3'h0,13'h0000,2'h3,7'h01,8'h77,13'h0ABC,3'h7,1'h1,1'h0,9'h001,8'h00,2'h0);
        add(3'h0,13'h0000,2'h3,7'h0B,8'h0C,13'h0ABC,3'h7,1'h1,1'h0,9'h00B,8'h00,2'h0);
        add(3'h0,13'h0000,2'h3,7'h03,8'hC0,13'h0ABC,3'h7,1'h1,1'h0,9'h003,8'h00,2'h2);
        add(3'h0,13'h0000,2'h2,7'h01,8'h00,13'h0ABC,3'h7,1'h1,1'h0,9'h101,8'h77,2'h2);
        add(3'h0,13'h0000,2'h2,7'h0B,8'h00,13'h0ABC,3'h7,1'h1,1'h0,9'h10B,8'h0C,2'h2);
        // Pointer high bit set: only the large file owns bank 2 at 21h
        add(3'h0,13'h0000,2'h2,7'h00,8'h00,13'h0ABC,3'h4,1'h0,1'h1,9'h121,8'h00,2'h2);
        add(3'h0,13'h0000,2'h2,7'h00,8'h00,13'h0ABC,3'h3,1'h0,1'h0,9'h121,8'h00,2'h2);
        add(3'h0,13'h0000,2'h3,7'h03,8'h00,13'h0ABC,3'h7,1'h1,1'h0,9'h103,8'h00,2'h0);
        // Landing cycle of a counter-low write is left open, so only the settled value counts
        add(3'h0,13'h0000,2'h3,7'h02,8'h34,13'h0000,3'h0,1'h0,1'h0,9'h000,8'h00,2'h0);
        add(3'h0,13'h0000,2'h0,7'h00,8'h00,13'h0134,3'h7,1'h0,1'h0,9'h000,8'h00,2'h0);
        run_rows();
        for (int i = 0; i < 3; i++) chk_byte("pointer", 8'h21, ptr[i]);
        reset_pulse();
        rows.delete();
        add(3'h0,13'h0000,2'h2,7'h20,8'h00,13'h0000,3'h7,1'h0,1'h1,9'h020,8'h00,2'h0);
        add(3'h1,13'h0000,2'h0,7'h00,8'h00,13'h0001,3'h7,1'h0,1'h0,9'h000,8'h00,2'h0);
        run_rows();
        conclude();
    end
endmodule : program_data_memory_map_tb_top
